// ---- common/pcb_pkg.sv ----
package pcb_pkg;

   // System clock rate and the bus clock that host mode derives from it.
   localparam int SYS_CLK_MHZ = 100;
   localparam int HOST_BUS_CLK_MHZ = 25;
   // Documented bus clock range; 25 MHz sits inside the slow band.
   localparam int BUS_CLK_MIN_MHZ = 20;
   localparam int BUS_CLK_MAX_MHZ = 33;
   localparam int BUS_CLK_FAST_MHZ = 66;
   localparam int DIV_CYCLES = SYS_CLK_MHZ / HOST_BUS_CLK_MHZ;
   localparam int HALF_CYCLES = DIV_CYCLES / 2;
   localparam int DIV_CNT_W = 2;
   localparam logic [DIV_CNT_W-1:0] DIV_CNT_ZERO = 2'h0;
   localparam logic [DIV_CNT_W-1:0] DIV_CNT_ONE = 2'h1;
   localparam logic [DIV_CNT_W-1:0] HALF_LAST = DIV_CNT_W'(HALF_CYCLES - 1);

   // Bus clocks between a failing address and the error strobe.
   localparam int SERR_DELAY_CLKS = 2;

   // System clocks from reset release to the strap capture. The filter output
   // settles on the fourth edge, so the capture waits for the fifth.
   localparam int STRAP_SETTLE = 5;
   localparam logic [2:0] SETTLE_ZERO = 3'h0;
   localparam logic [2:0] SETTLE_ONE = 3'h1;
   localparam logic [2:0] SETTLE_LAST = 3'(STRAP_SETTLE - 1);

   localparam int NUM_BUS_CLKS = 4;

   // Bus signals sampled on the bus clock.
   typedef struct packed {
      logic frame_n;
      logic [31:0] ad;
      logic [3:0] cbe_n;
      logic par;
      logic perr_n;
   } pcb_bus_in_t;

   // Open-drain pin: out is the level driven while oe is high.
   typedef struct packed {
      logic out;
      logic oe;
   } pcb_od_pin_t;

   // Requests from the bus core, all on the bus clock.
   typedef struct packed {
      logic master_active;
      logic burst_done;
      logic error_clear;
      logic pme_clear;
   } pcb_core_ctl_t;

   // Status back to the bus core, all on the bus clock; master_halt is decoded from the state register.
   typedef struct packed {
      logic addr_parity_err;
      logic master_parity_err;
      logic master_halt;
      logic bus_speed_66;
   } pcb_core_sts_t;

   // Master error sequence.
   typedef enum logic [2:0] {
      MS_RUN = 3'h1,
      MS_FINISH = 3'h2,
      MS_HALT = 3'h4
   } pcb_master_st_t;

   // Even parity over address and command lanes.
   function automatic logic pcb_even_parity(input logic [31:0] ad, input logic [3:0] cbe_n);
      return ^{ad, cbe_n};
   endfunction

endpackage

// ---- design/pcb_sync3.sv ----
`timescale 1ns/1ps
module pcb_sync3 #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   import pcb_pkg::*;

   logic [WIDTH-1:0] stage1_ff;
   logic [WIDTH-1:0] stage2_ff;
   logic [WIDTH-1:0] stage3_ff;
   logic [WIDTH-1:0] held_ff;
   logic [WIDTH-1:0] nxt_held;

   // Three-stage chain; only the second stage reads the first.
   always_ff @(posedge clk) begin
      if (rst) begin
         stage1_ff <= '0;
         stage2_ff <= '0;
         stage3_ff <= '0;
      end else begin
         stage1_ff <= async_in;
         stage2_ff <= stage1_ff;
         stage3_ff <= stage2_ff;
      end
   end

   // A change is accepted only once the second and third stages agree.
   always_comb begin
      nxt_held = (stage2_ff & ~(stage2_ff ^ stage3_ff)) | (held_ff & (stage2_ff ^ stage3_ff));
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         held_ff <= '0;
      end else begin
         held_ff <= nxt_held;
      end
   end

   assign sync_out = held_ff;

endmodule

// ---- design/pcb_clk_div.sv ----
`timescale 1ns/1ps
module pcb_clk_div (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic run,
   output logic clk_out
);
   import pcb_pkg::*;

   logic [DIV_CNT_W-1:0] cnt_ff;
   logic clk_ff;

   // Half-period counter; it keeps turning while stopped so restarts stay simple.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cnt_ff <= DIV_CNT_ZERO;
      end else if (cnt_ff == HALF_LAST) begin
         cnt_ff <= DIV_CNT_ZERO;
      end else begin
         cnt_ff <= cnt_ff + DIV_CNT_ONE;
      end
   end

   // A high phase always completes, so stopping never leaves a runt pulse.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         clk_ff <= 1'b0;
      end else if ((cnt_ff == HALF_LAST) && (run || clk_ff)) begin
         clk_ff <= ~clk_ff;
      end
   end

   assign clk_out = clk_ff;

endmodule

// ---- design/pcb_sideband.sv ----
`timescale 1ns/1ps
// Behaviour
// - Address parity fault drives the open-drain system error low two clocks later.
// - A high 66 MHz enable input means the bus segment runs at 66 MHz.
// - All bus signals are sampled on the rising edge of the bus clock.
// - The bus clock runs at 20 to 33 MHz or 66 MHz.
// - Host mode drives the primary bus clock, looped back to the bus clock input.
// - Guest mode leaves the primary bus clock output unused.
// - The clock-run line is never driven by this device.
// - Mini card active is driven low, open drain, while full performance is needed.
// - Strap high selects host mode and enables the on-chip arbiter.
// - Strap low selects guest mode and keeps the arbiter disabled.
// - Power event output is active low, open drain, released when idle.
// - Power event output is asserted when a wake-up event is seen.
// - Master parity error sets status, finishes the burst, halts until cleared.
module pcb_sideband (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic pci_clk,
   input wire logic bridge_mode_strap,
   input wire logic m66_enable,
   input pcb_pkg::pcb_bus_in_t bus_in,
   input pcb_pkg::pcb_core_ctl_t core_ctl,
   output pcb_pkg::pcb_core_sts_t core_sts,
   input wire logic clock_run_request_n_in,
   input wire logic function_busy,
   input wire logic wake_event,
   input wire logic clock_stop_req,
   output logic host_mode,
   output logic arbiter_enable,
   output logic bus_clock_out_primary,
   output logic bus_clock_out_b,
   output logic bus_clock_out_c,
   output logic bus_clock_out_d,
   output pcb_pkg::pcb_od_pin_t system_error_n,
   output pcb_pkg::pcb_od_pin_t clock_run_request_n,
   output pcb_pkg::pcb_od_pin_t mini_card_active_n,
   output pcb_pkg::pcb_od_pin_t power_event_n
);
   import pcb_pkg::*;

   // System-domain state.
   logic [1:0] pin_sync;
   logic strap_sync;
   logic clkrun_sync_n;
   logic [2:0] settle_ff;
   logic strap_done_ff;
   logic host_mode_ff;
   logic arbiter_enable_ff;
   logic clocks_run_ff;
   logic div_clk;
   logic [NUM_BUS_CLKS-1:0] bus_clk_ff;
   logic mini_active_ff;
   logic wake_tgl_ff;

   // Bus-domain state.
   logic rst_pci_meta_ff;
   logic rst_pci_ff;
   logic frame_n_prev_ff;
   logic addr_phase_ff;
   logic parity_calc_ff;
   logic serr_stage_ff;
   logic serr_oe_ff;
   logic addr_err_ff;
   logic master_err_ff;
   pcb_master_st_t master_st_ff;
   pcb_master_st_t nxt_master_st;
   logic perr_hit;
   logic m66_sync;
   logic m66_ff;
   logic wake_sync;
   logic wake_prev_ff;
   logic wake_pulse;
   logic pme_oe_ff;

   // Strap and clock-run pins come from outside; both are filtered together.
   // The clock-run pin enters inverted, so the filter's reset level means no request.
   pcb_sync3 #(
      .WIDTH(2)
   ) u_sys_pin_sync (
      .clk(clk_sys),
      .rst(reset),
      .async_in({bridge_mode_strap, !clock_run_request_n_in}),
      .sync_out(pin_sync)
   );

   assign strap_sync = pin_sync[1];
   assign clkrun_sync_n = !pin_sync[0];

   // Wait for the filter to fill before trusting the strap level.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         settle_ff <= SETTLE_ZERO;
      end else if (settle_ff != SETTLE_LAST) begin
         settle_ff <= settle_ff + SETTLE_ONE;
      end
   end

   // The strap is caught once after reset; later changes on the pin are ignored.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         strap_done_ff <= 1'b0;
         host_mode_ff <= 1'b0;
         arbiter_enable_ff <= 1'b0;
      end else if (!strap_done_ff && (settle_ff == SETTLE_LAST)) begin
         strap_done_ff <= 1'b1;
         host_mode_ff <= strap_sync;
         arbiter_enable_ff <= strap_sync;
      end
   end

   assign host_mode = host_mode_ff;
   assign arbiter_enable = arbiter_enable_ff;

   // Clocks run in host mode unless power management stops them; a clock-run
   // request from a card overrides the stop.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         clocks_run_ff <= 1'b0;
      end else begin
         clocks_run_ff <= host_mode_ff && (!clock_stop_req || !clkrun_sync_n);
      end
   end

   // Divider gives a 25 MHz bus clock, inside the slow band of the bus.
   pcb_clk_div u_bus_clk_div (
      .clk_sys(clk_sys),
      .reset(reset),
      .run(clocks_run_ff),
      .clk_out(div_clk)
   );

   // All four outputs come from parallel flops so they stay in phase.
   generate
      for (genvar gi = 0; gi < NUM_BUS_CLKS; gi++) begin : g_bus_clk
         always_ff @(posedge clk_sys) begin
            if (reset) begin
               bus_clk_ff[gi] <= 1'b0;
            end else begin
               bus_clk_ff[gi] <= div_clk && host_mode_ff;
            end
         end
      end
   endgenerate

   assign bus_clock_out_primary = bus_clk_ff[0];
   assign bus_clock_out_b = bus_clk_ff[1];
   assign bus_clock_out_c = bus_clk_ff[2];
   assign bus_clock_out_d = bus_clk_ff[3];

   // The clock-run line is only listened to, never driven.
   assign clock_run_request_n = '{out: 1'b0, oe: 1'b0};

   // Mini card active follows the busy level, pulling low while busy.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mini_active_ff <= 1'b0;
      end else begin
         mini_active_ff <= function_busy;
      end
   end

   assign mini_card_active_n = '{out: 1'b0, oe: mini_active_ff};

   // Wake events cross to the bus clock as a toggle, so a lone one-cycle event is not lost even
   // when the bus clock is slow.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wake_tgl_ff <= 1'b0;
      end else if (wake_event) begin
         wake_tgl_ff <= ~wake_tgl_ff;
      end
   end

   // Reset reaches the bus domain through two flops.
   always_ff @(posedge pci_clk) begin
      rst_pci_meta_ff <= reset;
      rst_pci_ff <= rst_pci_meta_ff;
   end

   pcb_sync3 #(
      .WIDTH(2)
   ) u_pci_sync (
      .clk(pci_clk),
      .rst(rst_pci_ff),
      .async_in({wake_tgl_ff, m66_enable}),
      .sync_out({wake_sync, m66_sync})
   );

   // The 66 MHz enable is reported to the core as the segment speed.
   always_ff @(posedge pci_clk) begin
      if (rst_pci_ff) begin
         m66_ff <= 1'b0;
      end else begin
         m66_ff <= m66_sync;
      end
   end

   // Address phase is the first edge with frame low; its parity arrives next edge.
   always_ff @(posedge pci_clk) begin
      if (rst_pci_ff) begin
         frame_n_prev_ff <= 1'b1;
         addr_phase_ff <= 1'b0;
         parity_calc_ff <= 1'b0;
      end else begin
         frame_n_prev_ff <= bus_in.frame_n;
         addr_phase_ff <= frame_n_prev_ff && !bus_in.frame_n;
         parity_calc_ff <= pcb_even_parity(bus_in.ad, bus_in.cbe_n);
      end
   end

   // Check one edge after the address, drive the strobe on the second edge.
   // The strobe lasts one bus clock; the pull-up returns the wire high.
   always_ff @(posedge pci_clk) begin
      if (rst_pci_ff) begin
         serr_stage_ff <= 1'b0;
         serr_oe_ff <= 1'b0;
      end else begin
         serr_stage_ff <= addr_phase_ff && (bus_in.par != parity_calc_ff);
         serr_oe_ff <= serr_stage_ff;
      end
   end

   assign system_error_n = '{out: 1'b0, oe: serr_oe_ff};

   // Sticky address parity status; a new fault beats a clear in the same cycle.
   always_ff @(posedge pci_clk) begin
      if (rst_pci_ff) begin
         addr_err_ff <= 1'b0;
      end else if (serr_stage_ff) begin
         addr_err_ff <= 1'b1;
      end else if (core_ctl.error_clear) begin
         addr_err_ff <= 1'b0;
      end
   end

   assign perr_hit = core_ctl.master_active && !bus_in.perr_n;

   // Master parity status; set wins over clear.
   always_ff @(posedge pci_clk) begin
      if (rst_pci_ff) begin
         master_err_ff <= 1'b0;
      end else if (perr_hit) begin
         master_err_ff <= 1'b1;
      end else if (core_ctl.error_clear) begin
         master_err_ff <= 1'b0;
      end
   end

   // After a master parity error the burst is allowed to finish, then the
   // master halts until the host clears the error.
   always_comb begin
      nxt_master_st = master_st_ff;
      unique case (master_st_ff)
         MS_RUN: begin
            if (perr_hit && core_ctl.burst_done) begin
               nxt_master_st = MS_HALT;
            end else if (perr_hit) begin
               nxt_master_st = MS_FINISH;
            end
         end
         MS_FINISH: begin
            if (core_ctl.burst_done) begin
               nxt_master_st = MS_HALT;
            end else if (core_ctl.error_clear) begin
               nxt_master_st = MS_RUN;
            end
         end
         MS_HALT: begin
            if (core_ctl.error_clear && !perr_hit) begin
               nxt_master_st = MS_RUN;
            end
         end
         default: begin
            nxt_master_st = MS_RUN;
         end
      endcase
   end

   always_ff @(posedge pci_clk) begin
      if (rst_pci_ff) begin
         master_st_ff <= MS_RUN;
      end else begin
         master_st_ff <= nxt_master_st;
      end
   end

   assign core_sts = '{addr_parity_err: addr_err_ff,
                       master_parity_err: master_err_ff,
                       master_halt: (master_st_ff == MS_HALT),
                       bus_speed_66: m66_ff};

   // Edge of the synchronised toggle marks one wake event.
   always_ff @(posedge pci_clk) begin
      if (rst_pci_ff) begin
         wake_prev_ff <= 1'b0;
      end else begin
         wake_prev_ff <= wake_sync;
      end
   end

   assign wake_pulse = wake_sync != wake_prev_ff;

   // Power event holds low until the host clears it; a wake wins over a clear.
   always_ff @(posedge pci_clk) begin
      if (rst_pci_ff) begin
         pme_oe_ff <= 1'b0;
      end else if (wake_pulse) begin
         pme_oe_ff <= 1'b1;
      end else if (core_ctl.pme_clear) begin
         pme_oe_ff <= 1'b0;
      end
   end

   assign power_event_n = '{out: 1'b0, oe: pme_oe_ff};

   // Checks on the bus clock domain.
   a_serr_delay: assert property (@(posedge pci_clk) disable iff (rst_pci_ff)
      $fell(bus_in.frame_n) ##1 (bus_in.par != parity_calc_ff) |-> ##2 system_error_n.oe)
      else $error("System error not driven two clocks after bad address parity.");

   a_serr_clean: assert property (@(posedge pci_clk) disable iff (rst_pci_ff)
      $fell(bus_in.frame_n) ##1 (bus_in.par == parity_calc_ff) |-> ##2 !system_error_n.oe)
      else $error("System error driven for a good address.");

   a_serr_pulse: assert property (@(posedge pci_clk) disable iff (rst_pci_ff)
      system_error_n.oe |-> ##1 !system_error_n.oe && (system_error_n.out == 1'b0))
      else $error("System error strobe longer than one clock or driven high.");

   a_speed_flag: assert property (@(posedge pci_clk) disable iff (rst_pci_ff)
      m66_sync[*2] |-> ##1 core_sts.bus_speed_66)
      else $error("Speed flag does not follow the 66 MHz enable.");

   a_halt_after: assert property (@(posedge pci_clk) disable iff (rst_pci_ff)
      (master_st_ff == MS_FINISH) && core_ctl.burst_done |=> core_sts.master_halt
      && core_sts.master_parity_err)
      else $error("Master did not halt after finishing the burst.");

   a_halt_hold: assert property (@(posedge pci_clk) disable iff (rst_pci_ff)
      core_sts.master_halt && !core_ctl.error_clear |=> core_sts.master_halt)
      else $error("Master left halt without an error clear.");

   a_wake_notify: assert property (@(posedge pci_clk) disable iff (rst_pci_ff)
      wake_pulse |=> power_event_n.oe && (power_event_n.out == 1'b0))
      else $error("Power event not asserted after a wake event.");

   a_pme_hold: assert property (@(posedge pci_clk) disable iff (rst_pci_ff)
      power_event_n.oe && !core_ctl.pme_clear |=> power_event_n.oe)
      else $error("Power event released without a clear.");

   // Checks on the system clock domain, then covers on both clocks.
   a_clkrun_quiet: assert property (@(posedge clk_sys) disable iff (reset)
      !clock_run_request_n.oe)
      else $error("Clock-run line driven.");

   a_host_arbiter: assert property (@(posedge clk_sys) disable iff (reset)
      !strap_done_ff && (settle_ff == SETTLE_LAST) && strap_sync |=> arbiter_enable && host_mode)
      else $error("High strap did not select host mode with the arbiter on.");

   a_guest_arbiter: assert property (@(posedge clk_sys) disable iff (reset)
      !strap_done_ff && (settle_ff == SETTLE_LAST) && !strap_sync |=> !arbiter_enable
      ##1 !arbiter_enable)
      else $error("Low strap left the arbiter enabled.");

   a_guest_clocks: assert property (@(posedge clk_sys) disable iff (reset)
      !host_mode |-> !bus_clock_out_primary && !bus_clock_out_b && !bus_clock_out_c
      && !bus_clock_out_d)
      else $error("Bus clock driven in guest mode.");

   a_clock_period: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(bus_clock_out_primary) && clocks_run_ff ##1 clocks_run_ff[*4]
      |-> $rose(bus_clock_out_primary))
      else $error("Primary bus clock period wrong while running.");

   a_sec_match: assert property (@(posedge clk_sys) disable iff (reset)
      $changed(bus_clock_out_primary) |-> (bus_clock_out_b == bus_clock_out_primary)
      && (bus_clock_out_c == bus_clock_out_primary) && (bus_clock_out_d == bus_clock_out_primary))
      else $error("Secondary bus clocks differ from the primary.");

   a_mini_active: assert property (@(posedge clk_sys) disable iff (reset)
      function_busy |=> mini_card_active_n.oe && (mini_card_active_n.out == 1'b0))
      else $error("Mini card active not driven while busy.");

   c_addr_fault: cover property (@(posedge pci_clk) disable iff (rst_pci_ff)
      system_error_n.oe);

   c_master_halt: cover property (@(posedge pci_clk) disable iff (rst_pci_ff)
      core_sts.master_halt ##1 !core_sts.master_halt);

   c_wake: cover property (@(posedge pci_clk) disable iff (rst_pci_ff)
      $rose(power_event_n.oe));

   c_clock_restart: cover property (@(posedge clk_sys) disable iff (reset)
      $rose(clocks_run_ff) && clock_stop_req);

endmodule

// ---- dv/pcb_host_model.sv ----
`timescale 1ns/1ps
// Far-side bus agent: a free-running bus clock plus address and error traffic.
module pcb_host_model (
   output logic link_clk,
   output pcb_pkg::pcb_bus_in_t bus_in,
   output logic m66_enable
);
   import pcb_pkg::*;

   // A bus clock runs free; the odd start offset keeps its edges 2 ns off the system clock edges.
   initial begin
      link_clk = 1'b0;
      #37;
      forever #80 link_clk = ~link_clk;
   end

   // Idle bus with no frame and no parity report.
   initial begin
      bus_in = '{frame_n: 1'b1, ad: 32'h0, cbe_n: 4'hf, par: 1'b0, perr_n: 1'b1};
      m66_enable = 1'b0;
   end

   // Speed pin is changed just after a rising edge, as every bus line is.
   task automatic set_m66(input logic v);
      @(posedge link_clk);
      #1 m66_enable = v;
   endtask

   // Address phase; bad flips the parity bit of the following clock.
   task automatic addr_phase(input logic bad);
      @(posedge link_clk);
      #1 bus_in.frame_n = 1'b0;
      bus_in.ad = 32'h1234_00a5;
      bus_in.cbe_n = 4'h6;
      @(posedge link_clk);
      #1 bus_in.par = bad ^ (^{bus_in.ad, bus_in.cbe_n});
      bus_in.frame_n = 1'b1;
      // The old address must not linger, so the lines show its inverse.
      bus_in.ad = ~bus_in.ad;
   endtask

   // One clock of reported data parity error.
   task automatic perr_pulse;
      @(posedge link_clk);
      #1 bus_in.perr_n = 1'b0;
      @(posedge link_clk);
      #1 bus_in.perr_n = 1'b1;
   endtask
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   import pcb_pkg::*;
   logic clk_sys, reset, strap, busy, wake, stop_req, crr_req_n;
   logic link_clk, m66, host_mode, arb_en, ck_a, ck_b, ck_c, ck_d;
   pcb_core_ctl_t ctl;
   pcb_core_sts_t sts;
   pcb_bus_in_t bus_in;
   pcb_od_pin_t serr, crr, mini, pme;
   int n_fail, n_tests, cyc, i;
   // Host mode loops the primary output back; reset needs the far clock to run.
   wire pci_clk = host_mode ? ck_a : link_clk;
   // Open-drain wires with pull-ups; the clock-run wire also carries the card's request.
   wire serr_w = serr.oe ? serr.out : 1'b1;
   wire pme_w = pme.oe ? pme.out : 1'b1;
   wire mini_w = mini.oe ? mini.out : 1'b1;
   wire crr_w = (crr.oe || !crr_req_n) ? 1'b0 : 1'b1;

   pcb_host_model u_host (.link_clk(link_clk), .bus_in(bus_in), .m66_enable(m66));
   pcb_sideband DUT (.clk_sys(clk_sys), .reset(reset), .pci_clk(pci_clk),
      .bridge_mode_strap(strap), .m66_enable(m66), .bus_in(bus_in), .core_ctl(ctl),
      .core_sts(sts), .clock_run_request_n_in(crr_w), .function_busy(busy),
      .wake_event(wake), .clock_stop_req(stop_req), .host_mode(host_mode),
      .arbiter_enable(arb_en), .bus_clock_out_primary(ck_a), .bus_clock_out_b(ck_b),
      .bus_clock_out_c(ck_c), .bus_clock_out_d(ck_d), .system_error_n(serr),
      .clock_run_request_n(crr), .mini_card_active_n(mini), .power_event_n(pme));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic finish_test;
      $display("checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask

   // The run should need some 1000 cycles; far beyond that it has hung.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail++;
         finish_test;
      end
   end

   // The clock-run line is watched on every cycle outside reset.
   always @(posedge clk_sys) begin
      if (!reset) begin
         check("clock run drive", 1'b0, crr.oe);
      end
   end

   // Reset is held long enough for the slow far clock to see it four times.
   task automatic do_reset(input logic mode);
      reset = 1'b1;
      strap = mode;
      repeat (64) @(posedge clk_sys);
      #1 reset = 1'b0;
      repeat (64) @(posedge clk_sys);
      #1;
   endtask

   task automatic pci_step;
      @(posedge pci_clk);
      #1;
   endtask

   task automatic t_guest;
      check("host mode", 1'b0, host_mode);
      check("arbiter", 1'b0, arb_en);
      for (i = 0; i < 40; i++) begin
         @(posedge clk_sys);
         #1 check("guest clocks", 1'b0, ck_a | ck_b | ck_c | ck_d);
      end
      $display("test guest done");
   endtask

   task automatic t_m66;
      u_host.set_m66(1'b1);
      repeat (5) pci_step;
      check("speed flag", 1'b1, sts.bus_speed_66);
      u_host.set_m66(1'b0);
      repeat (5) pci_step;
      check("speed flag", 1'b0, sts.bus_speed_66);
      $display("test m66 done");
   endtask

   // Good parity first, then bad: the strobe comes on the second clock only.
   task automatic t_addr;
      for (i = 0; i < 2; i++) begin
         u_host.addr_phase(i[0]);
         pci_step;
         pci_step;
         check("system error wire", !i[0], serr_w);
         check("address flag", i[0], sts.addr_parity_err);
         pci_step;
         check("system error wire", 1'b1, serr_w);
      end
      $display("test address parity done");
   endtask

   // A master error waits for the burst to end, then halts until cleared.
   task automatic t_master;
      ctl.master_active = 1'b1;
      u_host.perr_pulse;
      pci_step;
      check("master flag", 1'b1, sts.master_parity_err);
      check("halt early", 1'b0, sts.master_halt);
      ctl.burst_done = 1'b1;
      pci_step;
      ctl.burst_done = 1'b0;
      pci_step;
      check("halt", 1'b1, sts.master_halt);
      repeat (3) pci_step;
      check("halt held", 1'b1, sts.master_halt);
      ctl.error_clear = 1'b1;
      pci_step;
      ctl.error_clear = 1'b0;
      pci_step;
      check("halt cleared", 1'b0, sts.master_halt);
      check("master flag cleared", 1'b0, sts.master_parity_err);
      check("address flag cleared", 1'b0, sts.addr_parity_err);
      ctl.master_active = 1'b0;
      $display("test master error done");
   endtask

   task automatic t_wake;
      @(posedge clk_sys);
      #1 wake = 1'b1;
      @(posedge clk_sys);
      #1 wake = 1'b0;
      for (i = 0; i < 12 && pme_w !== 1'b0; i++) begin
         pci_step;
      end
      check("power event wire", 1'b0, pme_w);
      repeat (4) pci_step;
      check("power event held", 1'b0, pme_w);
      ctl.pme_clear = 1'b1;
      pci_step;
      ctl.pme_clear = 1'b0;
      repeat (2) pci_step;
      check("power event released", 1'b1, pme_w);
      $display("test wake done");
   endtask

   task automatic t_mini;
      @(posedge clk_sys);
      #1 busy = 1'b1;
      @(posedge clk_sys);
      #1 check("mini active wire", 1'b0, mini_w);
      busy = 1'b0;
      @(posedge clk_sys);
      #1 check("mini active wire", 1'b1, mini_w);
      $display("test mini active done");
   endtask

   // Host clocks: four identical outputs, two cycles high and two low.
   task automatic t_host;
      check("host mode", 1'b1, host_mode);
      check("arbiter", 1'b1, arb_en);
      @(posedge ck_a);
      #1;
      for (i = 0; i < 8; i++) begin
         check("primary clock", (i % 4) < 2, ck_a);
         check("secondary match", 1'b1, ck_b === ck_a && ck_c === ck_a && ck_d === ck_a);
         @(posedge clk_sys);
         #1;
      end
      stop_req = 1'b1;
      repeat (8) @(posedge clk_sys);
      #1 check("stopped clock", 1'b0, ck_a);
      crr_req_n = 1'b0;
      for (i = 0; i < 12 && ck_a !== 1'b1; i++) begin
         @(posedge clk_sys);
         #1;
      end
      check("clock restarted by request", 1'b1, ck_a);
      stop_req = 1'b0;
      crr_req_n = 1'b1;
      $display("test host clocks done");
   endtask

   initial begin
      reset = 1'b1;
      strap = 1'b0;
      busy = 1'b0;
      wake = 1'b0;
      stop_req = 1'b0;
      crr_req_n = 1'b1;
      ctl = '0;
      do_reset(1'b0);
      t_guest;
      t_m66;
      t_addr;
      t_master;
      t_wake;
      t_mini;
      do_reset(1'b1);
      t_host;
      finish_test;
   end
endmodule
